// File: logic/lhp_pkg.sv
// Constants and shared types for the LCD host serial/parallel port
// Notes on behaviour
// R1: Parallel strobe rises load upper, then lower nibble
// R2: Parallel read drives upper, then lower nibble on falls
// R3: Serial mode: pin 0 in, pin 3 out
// R4: Serial input shifts in MSB first on rise
// R5: Serial output shifts MSB first on fall
// R6: Interface mode strapped at reset release
// R7: Address enable strapped only in serial mode
// R8: Chip address compared when matching is on
// R9: Host straps unused chip addresses to 00
// R10: Inputs accepted only while selected and matched; the code needs only selection for commands, so they pass without a match
// R11: Chip select high floats data and busy
// R12: Host drives command high, data low
// R13: Byte captured on second strobe or eighth clock
// R14: Host settles command select before first fall
// R15: Host keeps command select low while reading
// R16: Busy low at byte end until processing done
// R17: Host waits while busy is low
// R18: Address mismatch floats busy output too
// R19: Master emits sync in last frame cycle
// R20: Sync pin direction follows configuration command
// R21: Configuration picks shared outputs and row range
// R22: Reset returns processing mode to write
// R23: Commands go to decoder, write data to memory
// R24: Read mode fetches next byte after eight bits
// R25: Reset clears nibble and bit counters
package lhp_pkg;

   localparam int NIBBLE_W = 4;
   localparam int BYTE_W = 8;
   localparam int ADDR_W = 2;

   // Pin roles on the nibble bus
   localparam int SERIAL_IN_POS = 0;
   localparam int MODE_SEL_POS = 1;
   localparam int ADDR_EN_POS = 2;
   localparam int SERIAL_OUT_POS = 3;

   // Cycles after reset release before strap pins have crossed the synchroniser
   localparam logic [1:0] STRAP_WAIT = 2'h3;

   // Last bit index of a serial byte
   localparam logic [2:0] LAST_BIT = 3'h7;

   // Reset values
   localparam logic [BYTE_W-1:0] XFER_RESET = 8'h00;
   localparam logic [ADDR_W-1:0] STRAP_ADDR_NONE = 2'h0;

   typedef enum logic [1:0] {
      LHP_IDLE = 2'b00,
      LHP_BUSY = 2'b01,
      LHP_FETCH = 2'b10
   } lhp_state_type;

endpackage : lhp_pkg

// File: logic/lhp_pin_if.sv
// Synchronised host pin levels and strobe edges between the pin stage and the port logic
`timescale 1ns/1ps
interface lhp_pin_if;
   logic cs_n;
   logic strobe_n;
   logic cmd_sel;
   logic [lhp_pkg::NIBBLE_W-1:0] nibble;
   logic [lhp_pkg::ADDR_W-1:0] straps;
   logic sync_in;
   logic strobe_rise;
   logic strobe_fall;
   logic sync_rise;

   modport source (output cs_n, strobe_n, cmd_sel, nibble, straps, sync_in, strobe_rise, strobe_fall, sync_rise);
   modport sink (input cs_n, strobe_n, cmd_sel, nibble, straps, sync_in, strobe_rise, strobe_fall, sync_rise);
endinterface : lhp_pin_if

// File: logic/lhp_pin_sync.sv
// Two-flop synchroniser for all host pins, with strobe and sync edge detection
`timescale 1ns/1ps
module lhp_pin_sync #(
   parameter int WIDTH = 10
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   // Raw pins, packed {sync, straps, nibble, cmd_sel, strobe_n, cs_n}
   input wire logic [WIDTH-1:0] raw,
   // Synchronised side
   lhp_pin_if.source pins
);

   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] sync;
   logic strobe_last;
   logic sync_last;

   // Reset leaves cs_n and strobe_n high so nothing looks selected or clocked
   localparam logic [WIDTH-1:0] IDLE_LEVEL = WIDTH'(3);

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta <= IDLE_LEVEL;
         sync <= IDLE_LEVEL;
      end else if (clk_en) begin
         meta <= raw;
         sync <= meta;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         strobe_last <= 1'b1;
         sync_last <= 1'b0;
      end else if (clk_en) begin
         strobe_last <= sync[1];
         sync_last <= sync[WIDTH-1];
      end
   end

   assign pins.cs_n = sync[0];
   assign pins.strobe_n = sync[1];
   assign pins.cmd_sel = sync[2];
   assign pins.nibble = sync[6:3];
   assign pins.straps = sync[8:7];
   assign pins.sync_in = sync[WIDTH-1];
   assign pins.strobe_rise = clk_en & sync[1] & ~strobe_last;
   assign pins.strobe_fall = clk_en & ~sync[1] & strobe_last;
   assign pins.sync_rise = clk_en & sync[WIDTH-1] & ~sync_last;

endmodule : lhp_pin_sync

// File: logic/lhp_host_port.sv
// Host serial/parallel port of the dot-matrix LCD controller
`timescale 1ns/1ps
module lhp_host_port (
   // Clock, reset, enable
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   // Host pins
   input wire logic cs_n,
   input wire logic strobe_or_shift_clock_n,
   input wire logic cmd_data_sel,
   input wire logic [lhp_pkg::ADDR_W-1:0] chip_id_straps,
   input wire logic [lhp_pkg::NIBBLE_W-1:0] nibble_bus_pins_in,
   output logic [lhp_pkg::NIBBLE_W-1:0] nibble_bus_pins_out,
   output logic [lhp_pkg::NIBBLE_W-1:0] nibble_bus_pins_oe,
   output logic busy_n_out,
   output logic busy_n_oe,
   // Frame sync pin
   input wire logic sync_in,
   output logic sync_out,
   output logic sync_oe,
   // Command decoder side
   output logic [lhp_pkg::BYTE_W-1:0] rx_byte,
   output logic rx_is_cmd,
   output logic cmd_valid,
   output logic mem_write_valid,
   input wire logic proc_done,
   input wire logic mode_set,
   input wire logic mode_read,
   input wire logic [lhp_pkg::ADDR_W-1:0] host_chip_addr,
   // Display memory read side
   output logic mem_fetch_req,
   input wire logic mem_fetch_valid,
   input wire logic [lhp_pkg::BYTE_W-1:0] mem_fetch_data,
   // Display configuration and timing
   input wire logic drive_config_cmd,
   input wire logic cfg_sync_master,
   input wire logic cfg_shared_as_rows,
   input wire logic cfg_rows_upper,
   input wire logic frame_last_cycle,
   output logic shared_row_col_outputs_rows,
   output logic dedicated_row_outputs_upper,
   output logic frame_align,
   // Strapped mode, for status
   output logic parallel_mode,
   output logic addr_match_enable
);

   lhp_pin_if pins ();

   logic [1:0] strap_cnt;
   logic strap_done;
   logic read_mode;
   logic [lhp_pkg::BYTE_W-1:0] xfer;
   logic nib_cnt;
   logic [2:0] bit_cnt;
   logic [lhp_pkg::NIBBLE_W-1:0] dout;
   logic drive_active;
   logic sync_master;
   lhp_pkg::lhp_state_type state;
   lhp_pkg::lhp_state_type next_state;
   logic addr_ok;
   logic selected;
   logic take_rise;
   logic take_fall;
   logic byte_end;
   logic deliver;
   logic fetch_now;

   lhp_pin_sync #(
      .WIDTH(10)
   ) u_pin_sync (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .raw({sync_in, chip_id_straps, nibble_bus_pins_in, cmd_data_sel, strobe_or_shift_clock_n, cs_n}),
      .pins(pins.source)
   );

   // Strap capture a fixed number of cycles after reset release
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         strap_cnt <= 2'h0;
         strap_done <= 1'b0;
         parallel_mode <= 1'b0;
         addr_match_enable <= 1'b0;
      end else if (clk_en && !strap_done) begin
         if (strap_cnt == lhp_pkg::STRAP_WAIT) begin
            strap_done <= 1'b1;
            parallel_mode <= pins.nibble[lhp_pkg::MODE_SEL_POS]; // [R6]
            addr_match_enable <= ~pins.nibble[lhp_pkg::MODE_SEL_POS]
               & pins.nibble[lhp_pkg::ADDR_EN_POS]; // [R7]
         end else begin
            strap_cnt <= strap_cnt + 2'h1;
         end
      end
   end

   // Address matching is always on in parallel mode
   assign addr_ok = !(parallel_mode || addr_match_enable) || (host_chip_addr == pins.straps); // [R8]
   assign selected = strap_done & ~pins.cs_n; // [R10]
   assign take_rise = selected & pins.strobe_rise;
   assign take_fall = selected & pins.strobe_fall;
   assign byte_end = take_rise && (parallel_mode ? nib_cnt : (bit_cnt == lhp_pkg::LAST_BIT)); // [R13]
   // Commands pass while selected so the address can be reloaded; data needs a match
   assign deliver = byte_end && !read_mode && (pins.cmd_sel || addr_ok); // [R10]

   // Data processing mode
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         read_mode <= 1'b0; // [R22]
      end else if (clk_en && mode_set) begin
         read_mode <= mode_read;
      end
   end

   // Nibble and bit position counters
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         nib_cnt <= 1'b0; // [R25]
         bit_cnt <= 3'h0; // [R25]
      end else if (clk_en) begin
         if (mode_set) begin
            nib_cnt <= 1'b0;
            bit_cnt <= 3'h0;
         end else if (take_rise) begin
            if (parallel_mode) begin
               nib_cnt <= ~nib_cnt;
            end else begin
               bit_cnt <= bit_cnt + 3'h1;
            end
         end
      end
   end

   // Transfer register
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         xfer <= lhp_pkg::XFER_RESET;
      end else if (clk_en) begin
         if (state == lhp_pkg::LHP_FETCH && mem_fetch_valid) begin
            xfer <= mem_fetch_data; // [R24]
         end else if (take_rise && parallel_mode && !read_mode) begin
            if (!nib_cnt) begin
               xfer[7:4] <= pins.nibble; // [R1]
            end else begin
               xfer[3:0] <= pins.nibble; // [R1]
            end
         end else if (take_rise && !parallel_mode) begin
            xfer <= {xfer[6:0], pins.nibble[lhp_pkg::SERIAL_IN_POS]}; // [R3] [R4]
         end
      end
   end

   // Output nibble, updated on strobe or shift clock falls
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         dout <= 4'h0;
         drive_active <= 1'b0;
      end else if (clk_en) begin
         if (!read_mode || pins.cs_n) begin
            drive_active <= 1'b0;
         end else if (take_fall) begin
            drive_active <= 1'b1;
            if (!parallel_mode) begin
               dout <= {xfer[7], 3'h0}; // [R5]
            end else if (!nib_cnt) begin
               dout <= xfer[7:4]; // [R2]
            end else begin
               dout <= xfer[3:0]; // [R2]
            end
         end
      end
   end

   // Busy and fetch sequencing
   always_comb begin
      next_state = state;
      unique case (state)
         lhp_pkg::LHP_IDLE: begin
            if (mode_set && mode_read) begin
               next_state = lhp_pkg::LHP_FETCH;
            end else if (byte_end && read_mode) begin
               next_state = lhp_pkg::LHP_FETCH; // [R24]
            end else if (deliver) begin
               next_state = lhp_pkg::LHP_BUSY; // [R16]
            end
         end
         lhp_pkg::LHP_BUSY: begin
            if (proc_done) begin
               next_state = lhp_pkg::LHP_IDLE; // [R16]
            end
         end
         lhp_pkg::LHP_FETCH: begin
            if (mem_fetch_valid) begin
               next_state = lhp_pkg::LHP_IDLE;
            end
         end
         default: begin
            next_state = lhp_pkg::LHP_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= lhp_pkg::LHP_IDLE;
      end else if (clk_en) begin
         state <= next_state;
      end
   end

   assign fetch_now = clk_en && (state == lhp_pkg::LHP_IDLE) && (next_state == lhp_pkg::LHP_FETCH);

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         mem_fetch_req <= 1'b0;
      end else begin
         mem_fetch_req <= fetch_now; // [R24]
      end
   end

   // Received byte hand-off
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_byte <= lhp_pkg::XFER_RESET;
         rx_is_cmd <= 1'b0;
         cmd_valid <= 1'b0;
         mem_write_valid <= 1'b0;
      end else begin
         cmd_valid <= 1'b0;
         mem_write_valid <= 1'b0;
         if (clk_en && deliver) begin
            rx_byte <= parallel_mode ? {xfer[7:4], pins.nibble}
               : {xfer[6:0], pins.nibble[lhp_pkg::SERIAL_IN_POS]}; // [R13]
            rx_is_cmd <= pins.cmd_sel; // [R13]
            cmd_valid <= pins.cmd_sel; // [R23]
            mem_write_valid <= ~pins.cmd_sel; // [R23]
         end
      end
   end

   // Pin drivers
   always_comb begin
      nibble_bus_pins_out = dout;
      nibble_bus_pins_oe = 4'h0;
      if (selected && addr_ok && read_mode && drive_active) begin // [R11]
         if (parallel_mode) begin
            nibble_bus_pins_oe = 4'hF; // [R2]
         end else begin
            nibble_bus_pins_oe[lhp_pkg::SERIAL_OUT_POS] = 1'b1; // [R3]
         end
      end
   end

   assign busy_n_out = (state == lhp_pkg::LHP_IDLE); // [R16]
   assign busy_n_oe = selected & addr_ok; // [R11] [R18]

   // Display configuration
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         sync_master <= 1'b0;
         shared_row_col_outputs_rows <= 1'b0;
         dedicated_row_outputs_upper <= 1'b0;
      end else if (clk_en && drive_config_cmd) begin
         sync_master <= cfg_sync_master; // [R20]
         shared_row_col_outputs_rows <= cfg_shared_as_rows; // [R21]
         dedicated_row_outputs_upper <= cfg_rows_upper; // [R21]
      end
   end

   // Frame sync: master emits, slave aligns to the received pulse
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         sync_out <= 1'b0;
         frame_align <= 1'b0;
      end else if (clk_en) begin
         sync_out <= sync_master & frame_last_cycle; // [R19]
         frame_align <= ~sync_master & pins.sync_rise; // [R19]
      end else begin
         frame_align <= 1'b0;
      end
   end

   assign sync_oe = sync_master; // [R20]

endmodule : lhp_host_port

// File: dv/lhp_host_props.sv
// Assertions on the ports of the host port top module
`timescale 1ns/1ps
module lhp_host_props (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   // Host pins
   input wire logic cs_n,
   input wire logic [lhp_pkg::NIBBLE_W-1:0] nibble_bus_pins_oe,
   input wire logic busy_n_out,
   input wire logic busy_n_oe,
   input wire logic parallel_mode,
   // Decoder and memory side
   input wire logic rx_is_cmd,
   input wire logic cmd_valid,
   input wire logic mem_write_valid,
   input wire logic proc_done,
   input wire logic mode_set,
   input wire logic mode_read,
   input wire logic mem_fetch_req,
   input wire logic mem_fetch_valid,
   // Configuration and sync
   input wire logic drive_config_cmd,
   input wire logic cfg_sync_master,
   input wire logic cfg_shared_as_rows,
   input wire logic cfg_rows_upper,
   input wire logic frame_last_cycle,
   input wire logic sync_out,
   input wire logic sync_oe,
   input wire logic shared_row_col_outputs_rows,
   input wire logic dedicated_row_outputs_upper
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   a_desel_float: assert property (cs_n [*3] |-> nibble_bus_pins_oe == 4'h0 && !busy_n_oe)
      else $error("Pins driven while deselected");
   a_busy_hold: assert property (!busy_n_out && !proc_done && !mem_fetch_valid |=> !busy_n_out)
      else $error("Busy released early");
   a_busy_free: assert property (!busy_n_out && (proc_done || mem_fetch_valid) |=> busy_n_out)
      else $error("Busy not released");
   a_cmd_qual: assert property (cmd_valid |-> rx_is_cmd ##1 !cmd_valid)
      else $error("Command pulse wrong");
   a_data_qual: assert property (mem_write_valid |-> !rx_is_cmd && !cmd_valid)
      else $error("Data pulse wrong");
   a_fetch_req: assert property (mode_set && mode_read |=> mem_fetch_req)
      else $error("No fetch after read mode");
   a_serial_oe: assert property (!parallel_mode |-> nibble_bus_pins_oe[2:0] == 3'h0)
      else $error("Serial mode drives wrong pins");
   a_sync_copy: assert property (sync_oe && $past(sync_oe) |-> sync_out == $past(frame_last_cycle))
      else $error("Sync pulse wrong");
   a_cfg_load: assert property (drive_config_cmd && clk_en |=> sync_oe == $past(cfg_sync_master)
      && shared_row_col_outputs_rows == $past(cfg_shared_as_rows) && dedicated_row_outputs_upper == $past(cfg_rows_upper))
      else $error("Configuration not loaded");
endmodule : lhp_host_props

// File: dv/lhp_host_model.sv
// Host CPU model moving bytes over the nibble bus by strobe or shift clock
`timescale 1ns/1ps
module lhp_host_model (
   // From the device
   input wire logic busy_n,
   input wire logic [3:0] pins,
   // Host drive
   output logic cs_n,
   output logic stb_n,
   output logic cmd_sel,
   output logic [3:0] nib
);
   logic off;
   initial begin
      off = 1'b0;
      cs_n = 1'b1;
      stb_n = 1'b1;
      cmd_sel = 1'b0;
      nib = 4'h0;
   end
   // n is 2 for nibbles or 8 for bits; rd releases the bus and collects q
   task automatic xfer(input int n, input logic cmd, input logic rd, input logic [7:0] d, output logic [7:0] q);
      logic [7:0] sh;
      sh = d;
      q = 8'h0;
      for (int w = 0; w < 100 && busy_n !== 1'b1; w++) #50;
      cs_n = off;
      cmd_sel = cmd & ~rd;
      #200;
      for (int i = 0; i < n; i++) begin
         stb_n = 1'b0;
         // A released line shows the inverse of its last level
         nib = rd ? ~nib : (n == 2) ? sh[7:4] : {3'h0, sh[7]};
         sh = (n == 2) ? sh << 4 : sh << 1;
         #200;
         stb_n = 1'b1;
         #200;
         q = (n == 2) ? {q[3:0], pins} : {q[6:0], pins[3]};
      end
      cs_n = 1'b1;
   endtask : xfer
endmodule : lhp_host_model

// File: dv/test_lcd_host_serial_parallel_port.sv
// Self-checking bench of the host port driven by the host model
`timescale 1ns/1ps
module test_lcd_host_serial_parallel_port;
   logic ref_clk, rst_b, proc_done, mode_set, mode_read, mem_fetch_valid, drive_config_cmd, frame_last_cycle;
   logic cfg_sync_master, cfg_shared_as_rows, cfg_rows_upper, sync_drv, busy_n_out, busy_n_oe, sync_out, sync_oe;
   logic rx_is_cmd, cmd_valid, mem_write_valid, mem_fetch_req, rows, upper, frame_align, parallel_mode, addr_en;
   logic cs_n, stb_n, cmd_sel, clk_en;
   logic [1:0] straps, host_addr;
   logic [3:0] nib_host, nib_out, nib_oe, seen;
   logic [7:0] rx_byte, fetch_data, q;
   int n_mismatch, samples_checked;
   wire logic [3:0] nib_wire = (nib_oe & nib_out) | (~nib_oe & nib_host);
   wire logic sync_wire = sync_oe ? sync_out : sync_drv;
   lhp_host_model i_host (.busy_n(busy_n_out), .pins(nib_wire), .cs_n(cs_n), .stb_n(stb_n), .cmd_sel(cmd_sel),
      .nib(nib_host));
   lhp_host_port i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .cs_n(cs_n), .strobe_or_shift_clock_n(stb_n),
      .cmd_data_sel(cmd_sel), .chip_id_straps(straps), .nibble_bus_pins_in(nib_wire), .nibble_bus_pins_out(nib_out),
      .nibble_bus_pins_oe(nib_oe), .busy_n_out(busy_n_out), .busy_n_oe(busy_n_oe), .sync_in(sync_wire),
      .sync_out(sync_out), .sync_oe(sync_oe), .rx_byte(rx_byte), .rx_is_cmd(rx_is_cmd), .cmd_valid(cmd_valid),
      .mem_write_valid(mem_write_valid), .proc_done(proc_done), .mode_set(mode_set), .mode_read(mode_read),
      .host_chip_addr(host_addr), .mem_fetch_req(mem_fetch_req), .mem_fetch_valid(mem_fetch_valid),
      .mem_fetch_data(fetch_data), .drive_config_cmd(drive_config_cmd), .cfg_sync_master(cfg_sync_master),
      .cfg_shared_as_rows(cfg_shared_as_rows), .cfg_rows_upper(cfg_rows_upper), .frame_last_cycle(frame_last_cycle),
      .shared_row_col_outputs_rows(rows), .dedicated_row_outputs_upper(upper), .frame_align(frame_align),
      .parallel_mode(parallel_mode), .addr_match_enable(addr_en));
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // Sticky record of one-cycle pulses
   always @(posedge ref_clk) seen <= seen | {frame_align, mem_fetch_req, mem_write_valid, cmd_valid};
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : cyc
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_byte
   task automatic chk_bit(input logic got, input logic exp);
      chk_byte({7'h0, got}, {7'h0, exp});
   endtask : chk_bit
   task automatic do_reset(input logic [3:0] strap_nib, input logic [1:0] ca);
      rst_b = 1'b0;
      i_host.nib = strap_nib;
      straps = ca;
      cyc(20);
      rst_b = 1'b1;
      cyc(8);
   endtask : do_reset
   task automatic send(input int n, input logic cmd, input logic [7:0] d);
      seen = 4'h0;
      i_host.xfer(n, cmd, 1'b0, d, q);
      cyc(2);
   endtask : send
   task automatic pulse_done;
      proc_done = 1'b1;
      cyc(1);
      proc_done = 1'b0;
      cyc(1);
   endtask : pulse_done
   task automatic read_mode(input logic rd);
      seen = 4'h0;
      mode_read = rd;
      mode_set = 1'b1;
      cyc(1);
      mode_set = 1'b0;
   endtask : read_mode
   task automatic serve(input logic [7:0] d);
      for (int i = 0; i < 40 && !seen[2]; i++) cyc(1);
      chk_bit(seen[2], 1'b1);
      fetch_data = d;
      mem_fetch_valid = 1'b1;
      cyc(1);
      mem_fetch_valid = 1'b0;
      seen = 4'h0;
      cyc(2);
   endtask : serve
   task automatic cfg(input logic [2:0] c);
      {cfg_sync_master, cfg_shared_as_rows, cfg_rows_upper} = c;
      drive_config_cmd = 1'b1;
      cyc(1);
      drive_config_cmd = 1'b0;
      cyc(1);
   endtask : cfg
   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : test_done
   initial begin
      {rst_b, proc_done, mode_set, mode_read, mem_fetch_valid, drive_config_cmd, frame_last_cycle} = 7'h0;
      {cfg_sync_master, cfg_shared_as_rows, cfg_rows_upper, sync_drv, seen} = 8'h0;
      n_mismatch = 0;
      samples_checked = 0;
      clk_en = 1'b1;
      host_addr = 2'h2;
      fetch_data = 8'h00;
      do_reset(4'h2, 2'h2);
      chk_bit(parallel_mode, 1'b1);
      send(2, 1'b1, 8'hA5);
      chk_byte(rx_byte, 8'hA5);
      chk_byte({4'h0, seen}, 8'h01);
      chk_bit(busy_n_out, 1'b0);
      pulse_done();
      chk_bit(busy_n_out, 1'b1);
      send(2, 1'b0, 8'h3C);
      chk_byte({rx_byte[7:4], seen}, 8'h32);
      pulse_done();
      host_addr = 2'h1;
      send(2, 1'b0, 8'h5A);
      chk_byte({4'h0, seen}, 8'h00);
      host_addr = 2'h2;
      i_host.off = 1'b1;
      send(2, 1'b1, 8'h77);
      chk_byte({nib_oe, seen[0], 2'h0, busy_n_oe}, 8'h00);
      i_host.off = 1'b0;
      $display("parallel write tests done");
      read_mode(1'b1);
      serve(8'h96);
      i_host.xfer(2, 1'b0, 1'b1, 8'h00, q);
      chk_byte(q, 8'h96);
      serve(8'h41);
      read_mode(1'b0);
      $display("parallel read test done");
      cfg(3'h7);
      chk_byte({5'h0, sync_oe, rows, upper}, 8'h07);
      frame_last_cycle = 1'b1;
      cyc(1);
      frame_last_cycle = 1'b0;
      chk_bit(sync_out, 1'b1);
      cfg(3'h0);
      chk_byte({5'h0, sync_oe, rows, upper}, 8'h00);
      // A held clock enable must freeze the configuration
      clk_en = 1'b0;
      cfg(3'h7);
      clk_en = 1'b1;
      chk_byte({5'h0, sync_oe, rows, upper}, 8'h00);
      seen = 4'h0;
      sync_drv = 1'b1;
      cyc(4);
      sync_drv = 1'b0;
      cyc(4);
      chk_bit(seen[3], 1'b1);
      $display("sync test done");
      host_addr = 2'h1;
      do_reset(4'h4, 2'h1);
      chk_byte({6'h0, parallel_mode, addr_en}, 8'h01);
      send(8, 1'b1, 8'hC3);
      chk_byte(rx_byte, 8'hC3);
      chk_bit(busy_n_out, 1'b0);
      pulse_done();
      host_addr = 2'h3;
      send(8, 1'b0, 8'h18);
      chk_byte({4'h0, seen}, 8'h00);
      host_addr = 2'h1;
      read_mode(1'b1);
      serve(8'hB4);
      i_host.xfer(8, 1'b0, 1'b1, 8'h00, q);
      chk_byte(q, 8'hB4);
      serve(8'h2E);
      $display("serial tests done");
      test_done();
   end
   initial begin
      #400000;
      n_mismatch++;
      test_done();
   end
endmodule : test_lcd_host_serial_parallel_port
bind lhp_host_port lhp_host_props i_props (.ref_clk, .rst_b, .clk_en, .cs_n, .nibble_bus_pins_oe, .busy_n_out, .busy_n_oe,
   .parallel_mode, .rx_is_cmd, .cmd_valid, .mem_write_valid, .proc_done, .mode_set, .mode_read, .mem_fetch_req,
   .mem_fetch_valid, .drive_config_cmd, .cfg_sync_master, .cfg_shared_as_rows, .cfg_rows_upper, .frame_last_cycle,
   .sync_out, .sync_oe, .shared_row_col_outputs_rows, .dedicated_row_outputs_upper);
